// *** dv/addressing_mode_decoder_tb_top.sv ***
// self-checking bench for the addressing mode decoder
`timescale 1ns/1ps
module addressing_mode_decoder_tb_top;
	import amd_pkg::*;
	logic        clk = 0, rst_n = 0, start = 0, rmw = 0, ce = 1, req, ack, busy, done, ill;
	logic [7:0]  pfx = 0, x = 8'h3C, y = 8'hC7, dat, imm;
	logic [3:0]  lat = 0;
	logic [15:0] pc = 0, addr, ea, npc;
	logic [2:0]  len;
	amd_mode_t   md = AMD_M_INHERENT;
	int          err_total, samples_checked;

	always #5 clk = ~clk;

	amd_decoder i_dut (.sys_clk_in(clk), .rst_n_in(rst_n), .clk_en_in(ce), .start_in(start),
		.prefix_in(pfx), .mode_in(md), .rmw_in(rmw), .pc_in(pc), .index_x_in(x), .index_y_in(y),
		.mem_ack_in(ack), .mem_data_in(dat), .mem_req_out(req), .mem_addr_out(addr),
		.busy_out(busy), .done_out(done), .illegal_out(ill), .ea_out(ea), .imm_out(imm),
		.length_out(len), .next_pc_out(npc));
	amd_mem_model i_mem (.sys_clk_in(clk), .rst_n_in(rst_n), .lat_in(lat), .req_in(req),
		.addr_in(addr), .ack_out(ack), .data_out(dat));

	function automatic logic [15:0] b(input logic [15:0] a);
		return {8'h00, i_mem.rd(a)};
	endfunction : b
	function automatic logic [15:0] w(input logic [15:0] a);
		return {i_mem.rd(a), i_mem.rd(a + 16'h0001)};
	endfunction : w
	function automatic logic [15:0] sx(input logic [15:0] v);
		return {{8{v[7]}}, v[7:0]};
	endfunction : sx

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic dec(input logic [7:0] p, input amd_mode_t m, input logic r, input logic [15:0] a,
		input logic [2:0] l, input logic [15:0] e, input logic ce);
		int n;
		@(negedge clk);
		pfx   = p;
		md    = m;
		rmw   = r;
		pc    = a;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		n     = 0;
		while (done !== 1'b1 && n < 60) begin
			@(negedge clk);
			n++;
		end
		chk(16'(n < 60), 16'h0001);
		chk(16'(len), 16'(l));
		chk(npc, a + 16'(l) - 16'h0001 - 16'(p != 8'h00));
		if (ce)
			chk(ea, e);
		chk(16'(ill), 16'(r && (m == AMD_M_DIR_LONG || m == AMD_M_IDX_LONG)));
		@(negedge clk);
		chk(16'(done), 16'h0000);
	endtask : dec

	task automatic t_direct;
		dec(8'h00, AMD_M_INHERENT, 0, 16'h0200, 3'd1, 16'h0000, 0);
		dec(8'h00, AMD_M_IMMEDIATE, 0, 16'h0341, 3'd2, 16'h0000, 0);
		chk(16'(imm), b(16'h0341));
		dec(8'h00, AMD_M_DIR_SHORT, 0, 16'h00A5, 3'd2, 16'h00FF, 1);
		dec(8'h00, AMD_M_DIR_LONG, 0, 16'h4410, 3'd3, w(16'h4410), 1);
	endtask : t_direct

	task automatic t_indexed;
		dec(8'h00, AMD_M_IDX_NONE, 0, 16'h0500, 3'd1, 16'(x), 1);
		dec(8'h90, AMD_M_IDX_NONE, 0, 16'h0500, 3'd2, 16'(y), 1);
		x = 8'hFF;
		dec(8'h00, AMD_M_IDX_SHORT, 0, 16'h00A5, 3'd2, 16'h01FE, 1);
		x = 8'h3C;
		dec(8'h90, AMD_M_IDX_SHORT, 0, 16'h0620, 3'd3, b(16'h0620) + 16'(y), 1);
		dec(8'h00, AMD_M_IDX_LONG, 0, 16'h7F31, 3'd3, w(16'h7F31) + 16'(x), 1);
	endtask : t_indexed

	task automatic t_indirect;
		dec(8'h92, AMD_M_DIR_SHORT, 0, 16'h0710, 3'd3, b(b(16'h0710)), 1);
		dec(8'h92, AMD_M_DIR_LONG, 0, 16'h0811, 3'd3, w(b(16'h0811)), 1);
		y = 8'hFF;
		dec(8'h91, AMD_M_IDX_SHORT, 0, 16'h00FF, 3'd3, b(b(16'h00FF)) + 16'h00FF, 1);
		y = 8'hC7;
		dec(8'h92, AMD_M_IDX_SHORT, 0, 16'h0912, 3'd3, b(b(16'h0912)) + 16'(x), 1);
		dec(8'h92, AMD_M_IDX_LONG, 0, 16'h0A13, 3'd3, w(b(16'h0A13)) + 16'(x), 1);
	endtask : t_indirect

	task automatic t_relative;
		dec(8'h00, AMD_M_REL, 0, 16'h12DA, 3'd2, 16'h12DB + sx(b(16'h12DA)), 1);
		dec(8'h00, AMD_M_REL, 0, 16'h0025, 3'd2, 16'h0026 + sx(b(16'h0025)), 1);
		dec(8'h92, AMD_M_REL, 0, 16'h0B14, 3'd3, 16'h0B15 + sx(b(b(16'h0B14))), 1);
	endtask : t_relative

	task automatic t_rmw_slow;
		dec(8'h00, AMD_M_DIR_SHORT, 1, 16'h0C10, 3'd2, b(16'h0C10), 1);
		dec(8'h00, AMD_M_DIR_LONG, 1, 16'h0C20, 3'd3, w(16'h0C20), 1);
		dec(8'h00, AMD_M_IDX_LONG, 1, 16'h0C30, 3'd3, w(16'h0C30) + 16'(x), 1);
		lat = 4'h3;
		dec(8'h92, AMD_M_IDX_LONG, 0, 16'h0D15, 3'd3, w(b(16'h0D15)) + 16'(x), 1);
		lat = 4'h0;
	endtask : t_rmw_slow

	task automatic t_bit;
		dec(8'h00, AMD_M_BIT, 0, 16'h0E16, 3'd2, b(16'h0E16), 1);
		dec(8'h00, AMD_M_BIT_REL, 0, 16'h0E17, 3'd3, 16'h0E19 + sx(b(16'h0E18)), 1);
	endtask : t_bit

	task automatic t_freeze;
		int n;
		@(negedge clk);
		ce    = 1'b0;
		pfx   = 8'h00;
		md    = AMD_M_DIR_SHORT;
		rmw   = 1'b0;
		pc    = 16'h00A5;
		start = 1'b1;
		repeat (3) @(negedge clk);
		chk(16'(busy), 16'h0000);
		ce = 1'b1;
		@(negedge clk);
		ce    = 1'b0;
		start = 1'b0;
		repeat (3) @(negedge clk);
		chk(16'({busy, req}), 16'h0002);
		ce = 1'b1;
		n  = 0;
		while (done !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		chk(16'(n < 20), 16'h0001);
		chk(ea, 16'h00FF);
	endtask : t_freeze

	task automatic t_reset;
		@(negedge clk);
		lat   = 4'h5;
		pfx   = 8'h00;
		md    = AMD_M_DIR_LONG;
		rmw   = 1'b0;
		pc    = 16'h0F20;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		repeat (3) @(negedge clk);
		chk(16'({busy, req}), 16'h0003);
		rst_n = 1'b0;
		#1;
		chk(16'({busy, req, done}), 16'h0000);
		@(negedge clk);
		rst_n = 1'b1;
		lat   = 4'h0;
		@(negedge clk);
		chk(16'({busy, req, done}), 16'h0000);
	endtask : t_reset

	task automatic summarize;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : summarize

	initial begin
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		chk(16'(done), 16'h0000);
		chk(16'(req), 16'h0000);
		t_direct();
		t_indexed();
		t_indirect();
		t_relative();
		t_bit();
		t_freeze();
		t_reset();
		t_rmw_slow();
		summarize();
	end

	initial begin
		#100000;
		err_total++;
		summarize();
	end
endmodule : addressing_mode_decoder_tb_top

// *** dv/amd_mem_model.sv ***
// memory partner answering decoder byte requests
`timescale 1ns/1ps
module amd_mem_model (
	input  wire logic        sys_clk_in,
	input  wire logic        rst_n_in,
	input  wire logic [3:0]  lat_in,
	input  wire logic        req_in,
	input  wire logic [15:0] addr_in,
	output logic             ack_out,
	output logic [7:0]       data_out
);
	logic [3:0] cnt;

	function automatic logic [7:0] rd(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5A;
	endfunction : rd

	// data valid only with ack, inverted otherwise
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ack_out  <= 1'b0;
			data_out <= 8'h00;
			cnt      <= 4'h0;
		end else if (ack_out) begin
			ack_out  <= 1'b0;
			data_out <= ~data_out;
		end else if (req_in && cnt == lat_in) begin
			ack_out  <= 1'b1;
			data_out <= rd(addr_in);
			cnt      <= 4'h0;
		end else if (req_in) begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule : amd_mem_model

// *** src/amd_adder.sv ***
// unsigned index adder with carry kept
`timescale 1ns/1ps
module amd_adder #(
	parameter int AW = 16
) (
	input  wire logic [AW-1:0] base_in,
	input  wire logic [7:0]    index_in,
	output logic      [AW-1:0] sum_out
);
	assign sum_out = base_in + {{(AW-8){1'b0}}, index_in};
endmodule : amd_adder

// *** src/amd_decoder.sv ***
// operand addressing mode decode and effective address generation
// What this block does
// - inherent: one byte, no operand fetch
// - immediate: one operand byte used directly
// - short direct: one address byte, page zero
// - long direct: two address bytes, full space
// - indexed address is index plus offset, unsigned
// - no-offset indexed: index alone, no byte
// - short indexed: untruncated sum up to 1FE
// - long indexed: word offset plus index
// - indirect: pointer read from memory is address
// - short indirect: byte pointer, page zero
// - long indirect: byte address, word pointer
// - indirect indexed: pointer plus index register
// - short indirect indexed reaches 1FE
// - branch target from next instruction counter
// - read-modify-write ops use short addressing only
// - no-offset indexed: second index adds one byte
// - relative adds signed eight-bit offset
// - prefixes 90, 92, 91 alter next opcode
`timescale 1ns/1ps
module amd_decoder (
	input  wire logic                  sys_clk_in,
	input  wire logic                  rst_n_in,
	input  wire logic                  clk_en_in,
	input  wire logic                  start_in,
	input  wire logic [7:0]            prefix_in,
	input  wire amd_pkg::amd_mode_t    mode_in,
	input  wire logic                  rmw_in,
	input  wire logic [amd_pkg::AMD_AW-1:0] pc_in,
	input  wire logic [7:0]            index_x_in,
	input  wire logic [7:0]            index_y_in,
	input  wire logic                  mem_ack_in,
	input  wire logic [7:0]            mem_data_in,
	output logic                       mem_req_out,
	output logic [amd_pkg::AMD_AW-1:0] mem_addr_out,
	output logic                       busy_out,
	output logic                       done_out,
	output logic                       illegal_out,
	output logic [amd_pkg::AMD_AW-1:0] ea_out,
	output logic [7:0]                 imm_out,
	output logic [2:0]                 length_out,
	output logic [amd_pkg::AMD_AW-1:0] next_pc_out
);
	import amd_pkg::*;

	amd_state_t       state;
	amd_mode_t        mode;
	logic             use_y;
	logic             indirect;
	logic             rmw;
	logic [15:0]      fetch_pc;
	logic [1:0]       left;
	logic             ptr_word;
	logic [7:0]       rel_off;
	logic [2:0]       len;
	logic [15:0]      word;
	logic             w_clear;
	logic             w_hi;
	logic             w_lo;
	logic [7:0]       idx;
	logic [15:0]      idx_sum;
	logic [15:0]      pc_after;
	logic [15:0]      rel_target;

	assign idx = use_y ? index_y_in : index_x_in;

	// two-byte words high byte first
	amd_word_asm u_word (
		.sys_clk_in (sys_clk_in),
		.rst_n_in   (rst_n_in),
		.clk_en_in  (clk_en_in),
		.clear_in   (w_clear),
		.load_hi_in (w_hi),
		.load_lo_in (w_lo),
		.byte_in    (mem_data_in),
		.word_out   (word)
	);

	amd_adder #(.AW(AMD_AW)) u_add (
		.base_in  (word),
		.index_in (idx),
		.sum_out  (idx_sum)
	);

	assign pc_after   = fetch_pc;
	assign rel_target = pc_after + {{8{rel_off[7]}}, rel_off};

	logic ack;
	assign ack = mem_req_out && mem_ack_in;

	// word loader strobes: first data byte high when a word is pending
	always_comb begin
		w_clear = start_in && state == AMD_S_IDLE;
		w_hi    = 1'b0;
		w_lo    = 1'b0;
		if (ack) begin
			case (state)
				AMD_S_OPER: begin
					if (left == 2'd2)
						w_hi = 1'b1;
					else
						w_lo = 1'b1;
				end
				AMD_S_PTRH: begin
					// byte pointers land low, word pointers start high
					w_hi = ptr_word;
					w_lo = !ptr_word;
				end
				AMD_S_PTRL: w_lo = 1'b1;
				default:    w_lo = 1'b0;
			endcase
		end
	end

	// sequencer
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state        <= AMD_S_IDLE;
			mode         <= AMD_M_INHERENT;
			use_y        <= 1'b0;
			indirect     <= 1'b0;
			rmw          <= 1'b0;
			fetch_pc     <= 16'h0000;
			left         <= 2'd0;
			ptr_word     <= 1'b0;
			rel_off      <= 8'h00;
			len          <= 3'd0;
			mem_req_out  <= 1'b0;
			mem_addr_out <= 16'h0000;
			busy_out     <= 1'b0;
			done_out     <= 1'b0;
			illegal_out  <= 1'b0;
			ea_out       <= 16'h0000;
			imm_out      <= 8'h00;
			length_out   <= 3'd0;
			next_pc_out  <= 16'h0000;
		end else if (clk_en_in) begin
			done_out <= 1'b0;
			case (state)
				AMD_S_IDLE: begin
					if (start_in) begin
						mode        <= mode_in;
						rmw         <= rmw_in;
						illegal_out <= 1'b0;
						use_y    <= prefix_in == AMD_PFX_SECOND || prefix_in == AMD_PFX_SEC_IND;
						indirect <= prefix_in == AMD_PFX_IND || prefix_in == AMD_PFX_SEC_IND;
						fetch_pc <= pc_in;
						busy_out <= 1'b1;
						len      <= (prefix_in == AMD_PFX_SECOND || prefix_in == AMD_PFX_IND
							|| prefix_in == AMD_PFX_SEC_IND) ? 3'd2 : 3'd1;
						ptr_word <= mode_in == AMD_M_DIR_LONG || mode_in == AMD_M_IDX_LONG;
						case (mode_in)
							AMD_M_INHERENT, AMD_M_IDX_NONE: left <= 2'd0;
							AMD_M_DIR_LONG, AMD_M_IDX_LONG: begin
								if (prefix_in == AMD_PFX_IND || prefix_in == AMD_PFX_SEC_IND)
									left <= 2'd1;
								else
									left <= 2'd2;
							end
							default:                        left <= 2'd1;
						endcase
						state <= AMD_S_OPER;
					end
				end
				AMD_S_OPER: begin
					if (left == 2'd0 && !mem_req_out) begin
						// operands consumed; pick the follow-up
						if (indirect && mode != AMD_M_INHERENT && mode != AMD_M_IMMEDIATE
							&& mode != AMD_M_IDX_NONE) begin
							// pointer address is one byte only
							mem_req_out  <= 1'b1;
							mem_addr_out <= {8'h00, word[7:0]};
							state        <= AMD_S_PTRH;
						end else if (mode == AMD_M_REL || mode == AMD_M_BIT_REL) begin
							rel_off <= word[7:0];
							state   <= AMD_S_DONE;
						end else begin
							state <= AMD_S_DONE;
						end
					end else if (ack) begin
						mem_req_out <= 1'b0;
						fetch_pc    <= fetch_pc + 16'h0001;
						len         <= len + 3'd1;
						left        <= left - 2'd1;
						if (mode == AMD_M_BIT_REL && left == 2'd1)
							rel_off <= mem_data_in;
					end else if (!mem_req_out) begin
						mem_req_out  <= 1'b1;
						mem_addr_out <= fetch_pc;
						// bit-relative: address byte then offset byte
						if (mode == AMD_M_BIT_REL && left == 2'd1 && len < 3'd2)
							left <= 2'd2;
					end
				end
				AMD_S_PTRH: begin
					if (ack) begin
						if (ptr_word) begin
							mem_addr_out <= mem_addr_out + 16'h0001;
							state        <= AMD_S_PTRL;
						end else begin
							mem_req_out <= 1'b0;
							if (mode == AMD_M_REL)
								rel_off <= mem_data_in;
							state <= AMD_S_DONE;
						end
					end
				end
				AMD_S_PTRL: begin
					if (ack) begin
						mem_req_out <= 1'b0;
						state       <= AMD_S_DONE;
					end
				end
				AMD_S_DONE: begin
					busy_out    <= 1'b0;
					done_out    <= 1'b1;
					length_out  <= len;
					next_pc_out <= fetch_pc;
					imm_out     <= word[7:0];
					case (mode)
						AMD_M_IDX_NONE:  ea_out <= {8'h00, idx};
						AMD_M_IDX_SHORT: ea_out <= indirect ? idx_sum : {7'h00, idx_sum[8:0]};
						AMD_M_IDX_LONG:  ea_out <= idx_sum;
						AMD_M_REL:       ea_out <= rel_target;
						AMD_M_BIT_REL:   ea_out <= rel_target;
						AMD_M_DIR_SHORT, AMD_M_BIT:
							ea_out <= {8'h00, word[7:0]};
						default:         ea_out <= word;
					endcase
					illegal_out <= rmw && (mode == AMD_M_DIR_LONG || mode == AMD_M_IDX_LONG || ptr_word);
					state <= AMD_S_IDLE;
				end
				default: state <= AMD_S_IDLE;
			endcase
		end
	end

	// checks
	property p_inherent_len;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		done_out && mode == AMD_M_INHERENT && !use_y && !indirect |-> length_out == 3'd1;
	endproperty
	a_inherent_len: assert property (p_inherent_len) else $error("inherent length wrong");
	property p_imm_len;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		done_out && mode == AMD_M_IMMEDIATE |-> length_out == 3'd2 + {2'b00, use_y || indirect};
	endproperty
	a_imm_len: assert property (p_imm_len) else $error("immediate length wrong");
	property p_short_dir;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		done_out && mode == AMD_M_DIR_SHORT |-> ea_out <= AMD_PAGE0_MAX;
	endproperty
	a_short_dir: assert property (p_short_dir) else $error("short direct off page zero");
	property p_short_idx;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		done_out && mode == AMD_M_IDX_SHORT && !indirect |-> ea_out <= AMD_SHORTX_MAX;
	endproperty
	a_short_idx: assert property (p_short_idx) else $error("short indexed out of range");
	property p_noidx;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		done_out && mode == AMD_M_IDX_NONE |-> ea_out == {8'h00, $past(idx)};
	endproperty
	a_noidx: assert property (p_noidx) else $error("no-offset indexed address wrong");
	property p_busy_done;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		$rose(busy_out) |-> ##[1:40] done_out;
	endproperty
	a_busy_done: assert property (p_busy_done) else $error("decode never finished");
	property p_req_hold;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		mem_req_out && !mem_ack_in && clk_en_in |=> mem_req_out && $stable(mem_addr_out);
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("request dropped before ack");
	property p_ptr_page0;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		state == AMD_S_PTRH && $past(state) == AMD_S_OPER |-> mem_addr_out[15:8] == 8'h00;
	endproperty
	a_ptr_page0: assert property (p_ptr_page0) else $error("pointer address not one byte");
	property p_long_dir_len;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		done_out && mode == AMD_M_DIR_LONG && !use_y && !indirect |-> length_out == 3'd3;
	endproperty
	a_long_dir_len: assert property (p_long_dir_len) else $error("long direct length wrong");
	property p_ind_long_len;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		done_out && indirect && (mode == AMD_M_DIR_LONG || mode == AMD_M_IDX_LONG) |-> length_out == 3'd3;
	endproperty
	a_ind_long_len: assert property (p_ind_long_len) else $error("indirect long length wrong");
	property p_y_noidx_len;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		done_out && mode == AMD_M_IDX_NONE && use_y |-> length_out == 3'd2;
	endproperty
	a_y_noidx_len: assert property (p_y_noidx_len) else $error("second index no-offset length wrong");
	property p_no_operand;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		busy_out && (mode == AMD_M_INHERENT || mode == AMD_M_IDX_NONE) |-> !mem_req_out;
	endproperty
	a_no_operand: assert property (p_no_operand) else $error("operand fetched for no-operand mode");
	property p_rel_reach;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		done_out && (mode == AMD_M_REL || mode == AMD_M_BIT_REL) |-> ea_out - next_pc_out + 16'h0080 <= 16'h00FF;
	endproperty
	a_rel_reach: assert property (p_rel_reach) else $error("branch target out of reach");
	property p_ptr_next_byte;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		state == AMD_S_PTRL && $past(state) == AMD_S_PTRH |-> mem_addr_out == $past(mem_addr_out) + 16'h0001;
	endproperty
	a_ptr_next_byte: assert property (p_ptr_next_byte) else $error("word pointer low byte address wrong");
	property p_rmw_long;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		done_out && rmw && (mode == AMD_M_DIR_LONG || mode == AMD_M_IDX_LONG) |-> illegal_out;
	endproperty
	a_rmw_long: assert property (p_rmw_long) else $error("long form rmw not flagged");
	property p_ind_idx_range;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		done_out && mode == AMD_M_IDX_SHORT && indirect |-> ea_out <= AMD_SHORTX_MAX;
	endproperty
	a_ind_idx_range: assert property (p_ind_idx_range) else $error("short indirect indexed out of range");
	property p_short_ind;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		done_out && mode == AMD_M_DIR_SHORT && indirect |-> ea_out <= AMD_PAGE0_MAX;
	endproperty
	a_short_ind: assert property (p_short_ind) else $error("short indirect off page zero");
	property p_imm_value;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		done_out && mode == AMD_M_IMMEDIATE |-> ea_out == {8'h00, imm_out};
	endproperty
	a_imm_value: assert property (p_imm_value) else $error("immediate operand not the fetched byte");
	property p_done_pulse;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		done_out && clk_en_in |=> !done_out;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done held past one cycle");
	property p_done_idle;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		done_out |-> !busy_out;
	endproperty
	a_done_idle: assert property (p_done_idle) else $error("busy still high at done");
	c_rel: cover property (@(posedge sys_clk_in) done_out && mode == AMD_M_REL);
	c_ind: cover property (@(posedge sys_clk_in) done_out && indirect && ptr_word);
	c_rmw: cover property (@(posedge sys_clk_in) illegal_out);
	c_bit_rel: cover property (@(posedge sys_clk_in) done_out && mode == AMD_M_BIT_REL);
	c_freeze: cover property (@(posedge sys_clk_in) busy_out && !clk_en_in);
endmodule : amd_decoder

// *** src/amd_pkg.sv ***
// shared constants and types for the addressing mode decoder
package amd_pkg;
	localparam int         AMD_AW          = 16;
	localparam int         AMD_DW          = 8;
	localparam logic [7:0] AMD_PFX_SECOND  = 8'h90;
	localparam logic [7:0] AMD_PFX_SEC_IND = 8'h91;
	localparam logic [7:0] AMD_PFX_IND     = 8'h92;
	localparam logic [15:0] AMD_PAGE0_MAX  = 16'h00FF;
	localparam logic [15:0] AMD_SHORTX_MAX = 16'h01FE;

	// base mode requested by the opcode decode ahead of this block
	typedef enum logic [3:0] {
		AMD_M_INHERENT  = 4'h0,
		AMD_M_IMMEDIATE = 4'h1,
		AMD_M_DIR_SHORT = 4'h2,
		AMD_M_DIR_LONG  = 4'h3,
		AMD_M_IDX_NONE  = 4'h4,
		AMD_M_IDX_SHORT = 4'h5,
		AMD_M_IDX_LONG  = 4'h6,
		AMD_M_REL       = 4'h7,
		AMD_M_BIT       = 4'h8,
		AMD_M_BIT_REL   = 4'h9
	} amd_mode_t;

	typedef enum logic [6:0] {
		AMD_S_IDLE = 7'b000_0001,
		AMD_S_OPER = 7'b000_0010,
		AMD_S_PTRH = 7'b000_0100,
		AMD_S_PTRL = 7'b000_1000,
		AMD_S_REL  = 7'b001_0000,
		AMD_S_DONE = 7'b010_0000,
		AMD_S_WAIT = 7'b100_0000
	} amd_state_t;
endpackage : amd_pkg

// *** src/amd_word_asm.sv ***
// assembles a two-byte value high byte first
`timescale 1ns/1ps
module amd_word_asm (
	input  wire logic       sys_clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       clk_en_in,
	input  wire logic       clear_in,
	input  wire logic       load_hi_in,
	input  wire logic       load_lo_in,
	input  wire logic [7:0] byte_in,
	output logic      [15:0] word_out
);
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			word_out <= 16'h0000;
		end else if (clk_en_in) begin
			if (clear_in)
				word_out <= 16'h0000;
			else if (load_hi_in)
				word_out <= {byte_in, 8'h00};
			else if (load_lo_in)
				word_out <= {word_out[15:8], byte_in};
		end
	end
endmodule : amd_word_asm
